// file: design/ows_pkg.sv
// Package for the output start-up write sequencer: map, step layout and timing.
package ows_pkg;

	// Register indices; the byte address of each is four times its index.
	localparam logic [7:0] PWR_ONE_IDX    = 8'h01;
	localparam logic [7:0] PWR_THREE_IDX  = 8'h03;
	localparam logic [7:0] LINE_MUTE_IDX  = 8'h1e;
	localparam logic [7:0] EAR_MUTE_IDX   = 8'h1f;
	localparam logic [7:0] ANTIPOP_A_IDX  = 8'h38;
	localparam logic [7:0] ANTIPOP_B_IDX  = 8'h39;
	localparam logic [7:0] SEQ_CTRL_IDX   = 8'h49;
	localparam logic [7:0] SEQ_STATUS_IDX = 8'hf0;

	// Register slots inside the block.
	localparam logic [3:0] SLOT_PWR_ONE   = 4'h0;
	localparam logic [3:0] SLOT_PWR_THREE = 4'h1;
	localparam logic [3:0] SLOT_LINE_MUTE = 4'h2;
	localparam logic [3:0] SLOT_EAR_MUTE  = 4'h3;
	localparam logic [3:0] SLOT_ANTIPOP_A = 4'h4;
	localparam logic [3:0] SLOT_ANTIPOP_B = 4'h5;
	localparam logic [3:0] SLOT_CTRL      = 4'h6;
	localparam logic [3:0] SLOT_STATUS    = 4'h7;
	localparam logic [3:0] SLOT_NONE      = 4'h8;
	localparam int         NUM_AREG       = 6;

	// Values after reset: outputs start muted, everything else off.
	localparam logic [15:0] PWR_ONE_RST   = 16'h0000;
	localparam logic [15:0] PWR_THREE_RST = 16'h0000;
	// All four line mute bits (6:5 and 2:1) set, so no line output is live after reset.
	localparam logic [15:0] LINE_MUTE_RST = 16'h0066;
	localparam logic [15:0] EAR_MUTE_RST  = 16'h0020;
	localparam logic [15:0] ANTIPOP_RST   = 16'h0000;
	localparam logic [15:0] CTRL_RST      = 16'h0000;

	// Launch values for the control register and their first step.
	localparam logic [7:0]  CTRL_LAUNCH   = 8'h01;
	localparam logic [15:0] CTRL_SPEAKER  = 16'h0110;
	localparam logic [15:0] CTRL_EARPIECE = 16'h0113;
	localparam logic [15:0] CTRL_LINEOUT  = 16'h0119;
	localparam logic [5:0]  STEP_SPEAKER  = 6'd16;
	localparam logic [5:0]  STEP_EARPIECE = 6'd19;
	localparam logic [5:0]  STEP_LINEOUT  = 6'd25;
	localparam logic [5:0]  STEP_BASE     = 6'd16;
	localparam int          STEP_COUNT    = 18;

	// Status field positions.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IDX_LSB  = 8;

	// Delay codes and their times.
	localparam logic [3:0] DLY_CODE_0 = 4'h0;
	localparam logic [3:0] DLY_CODE_9 = 4'h9;
	localparam logic [3:0] DLY_CODE_C = 4'hc;
	localparam logic [3:0] DLY_CODE_D = 4'hd;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned DLY_0_NS      = 562500;
	localparam int unsigned DLY_9_NS      = 32500000;
	localparam int unsigned DLY_C_NS      = 256500000;
	localparam int unsigned DLY_D_NS      = 512500000;
	localparam int unsigned DLY_0_CYC     = DLY_0_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY_9_CYC     = DLY_9_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY_C_CYC     = DLY_C_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY_D_CYC     = DLY_D_NS / CLK_PERIOD_NS;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_APPLY,
		ST_WAIT
	} ows_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] width;
		logic [3:0] start;
		logic [7:0] data;
		logic [3:0] dly;
		logic       end_of_sequence_flag;
	} ows_step_s;

endpackage

// file: design/ows_step_rom.sv
// Step memory holding the speaker, earpiece and line-output start-up steps.
`timescale 1ns/1ps
`default_nettype none
module ows_step_rom
	import ows_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       ce_i,
	// Read port
	input  wire logic [5:0] idx_i,
	output var  ows_step_s  step_o
);

	typedef struct packed {
		ows_step_s q;
	} ows_rom_s;

	ows_rom_s  s_reg;
	ows_rom_s  s_next;
	ows_step_s lut;

	always_comb begin
		case (idx_i)
			6'd16: lut = '{ANTIPOP_B_IDX, 4'd5, 4'd2, 8'h1b, 4'h0, 1'b0};
			6'd17: lut = '{PWR_ONE_IDX, 4'd3, 4'd0, 8'h03, 4'h9, 1'b0};
			6'd18: lut = '{PWR_ONE_IDX, 4'd2, 4'd12, 8'h03, 4'h0, 1'b1};
			6'd19: lut = '{ANTIPOP_B_IDX, 4'd6, 4'd1, 8'h27, 4'h0, 1'b0};
			6'd20: lut = '{ANTIPOP_A_IDX, 4'd1, 4'd6, 8'h01, 4'h0, 1'b0};
			6'd21: lut = '{PWR_ONE_IDX, 4'd1, 4'd11, 8'h01, 4'h0, 1'b0};
			6'd22: lut = '{PWR_ONE_IDX, 4'd3, 4'd0, 8'h03, 4'hc, 1'b0};
			6'd23: lut = '{ANTIPOP_B_IDX, 4'd1, 4'd1, 8'h00, 4'h0, 1'b0};
			6'd24: lut = '{EAR_MUTE_IDX, 4'd1, 4'd5, 8'h00, 4'h0, 1'b1};
			6'd25: lut = '{ANTIPOP_A_IDX, 4'd2, 4'd4, 8'h03, 4'h0, 1'b0};
			6'd26: lut = '{ANTIPOP_B_IDX, 4'd6, 4'd1, 8'h27, 4'h0, 1'b0};
			6'd27: lut = '{ANTIPOP_A_IDX, 4'd1, 4'd7, 8'h01, 4'h0, 1'b0};
			6'd28: lut = '{PWR_THREE_IDX, 4'd4, 4'd10, 8'h0f, 4'h0, 1'b0};
			6'd29: lut = '{ANTIPOP_A_IDX, 4'd2, 4'd4, 8'h00, 4'h0, 1'b0};
			6'd30: lut = '{PWR_ONE_IDX, 4'd3, 4'd0, 8'h03, 4'hd, 1'b0};
			6'd31: lut = '{ANTIPOP_B_IDX, 4'd1, 4'd1, 8'h00, 4'h0, 1'b0};
			6'd32: lut = '{LINE_MUTE_IDX, 4'd2, 4'd5, 8'h00, 4'h0, 1'b0};
			6'd33: lut = '{LINE_MUTE_IDX, 4'd2, 4'd1, 8'h00, 4'h0, 1'b1};
			// Unused slots end at once so a stray index cannot run away.
			default: lut = '{SEQ_STATUS_IDX, 4'd0, 4'd0, 8'h00, 4'h0, 1'b1};
		endcase
		s_next   = s_reg;
		s_next.q = lut;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign step_o = s_reg.q;

endmodule
`default_nettype wire

// file: design/ows_sequencer.sv
// Output start-up write sequencer with its AXI4-Lite register slave.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ows_sequencer
	import ows_pkg::*;
#(
	parameter int unsigned DLY_0_CYCLES = DLY_0_CYC,
	parameter int unsigned DLY_9_CYCLES = DLY_9_CYC,
	parameter int unsigned DLY_C_CYCLES = DLY_C_CYC,
	parameter int unsigned DLY_D_CYCLES = DLY_D_CYC
) (
	// Clock, reset and clock enable
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [11:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Analogue control registers
	output logic [15:0]      pwr_one_o,
	output logic [15:0]      pwr_three_o,
	output logic [15:0]      line_mute_o,
	output logic [15:0]      ear_mute_o,
	output logic [15:0]      antipop_a_o,
	output logic [15:0]      antipop_b_o,
	// Sequencer state
	output logic             busy_o,
	output logic [5:0]       step_index_o
);

	typedef struct packed {
		ows_state_e                  st;
		logic [5:0]                  idx;
		logic [31:0]                 cnt;
		logic                        end_of_sequence_flag;
		logic                        aw_hold;
		logic [7:0]                  aw_idx;
		logic                        w_hold;
		logic [15:0]                 wdata;
		logic [1:0]                  wstrb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [15:0]                 rdata;
		logic [1:0]                  rresp;
		logic [15:0]                 ctrl;
		logic [NUM_AREG-1:0][15:0]   areg;
	} ows_core_s;

	ows_core_s s_reg;
	ows_core_s s_next;
	ows_step_s step;
	logic      wr_do;
	logic      launch;
	logic [3:0] wr_slot;

	function automatic logic [3:0] reg_slot(input logic [7:0] idx);
		if (idx == PWR_ONE_IDX) begin
			reg_slot = SLOT_PWR_ONE;
		end else if (idx == PWR_THREE_IDX) begin
			reg_slot = SLOT_PWR_THREE;
		end else if (idx == LINE_MUTE_IDX) begin
			reg_slot = SLOT_LINE_MUTE;
		end else if (idx == EAR_MUTE_IDX) begin
			reg_slot = SLOT_EAR_MUTE;
		end else if (idx == ANTIPOP_A_IDX) begin
			reg_slot = SLOT_ANTIPOP_A;
		end else if (idx == ANTIPOP_B_IDX) begin
			reg_slot = SLOT_ANTIPOP_B;
		end else if (idx == SEQ_CTRL_IDX) begin
			reg_slot = SLOT_CTRL;
		end else if (idx == SEQ_STATUS_IDX) begin
			reg_slot = SLOT_STATUS;
		end else begin
			reg_slot = SLOT_NONE;
		end
	endfunction

	function automatic logic [31:0] dly_cycles(input logic [3:0] code);
		case (code)
			DLY_CODE_9: dly_cycles = DLY_9_CYCLES;
			DLY_CODE_C: dly_cycles = DLY_C_CYCLES;
			DLY_CODE_D: dly_cycles = DLY_D_CYCLES;
			default:    dly_cycles = DLY_0_CYCLES;
		endcase
	endfunction

	function automatic logic [15:0] field_mask(input logic [3:0] width, input logic [3:0] start);
		field_mask = ((16'h0001 << width) - 16'h0001) << start;
	endfunction

	ows_step_rom u_rom (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.ce_i   (ce_i),
		.idx_i  (s_reg.idx),
		.step_o (step)
	);

	assign wr_do   = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
	assign wr_slot = reg_slot(s_reg.aw_idx);
	// Only a full-width launch word while idle starts a run; later ones are dropped.
	assign launch  = wr_do && wr_slot == SLOT_CTRL && s_reg.wstrb == 2'b11
		&& s_reg.st == ST_IDLE && (s_reg.wdata == CTRL_SPEAKER
		|| s_reg.wdata == CTRL_EARPIECE || s_reg.wdata == CTRL_LINEOUT);

	always_comb begin
		logic [15:0] mask;
		logic [3:0]  rslot;
		mask   = field_mask(step.width, step.start);
		rslot  = reg_slot(s_axi_araddr_i[9:2]);
		s_next = s_reg;
		// Write channel: address and data are caught in either order.
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			s_next.aw_hold = 1'b1;
			s_next.aw_idx  = s_axi_awaddr_i[9:2];
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			s_next.w_hold = 1'b1;
			s_next.wdata  = s_axi_wdata_i[15:0];
			s_next.wstrb  = s_axi_wstrb_i[1:0];
		end
		if (s_reg.bvalid && s_axi_bready_i) begin
			s_next.bvalid = 1'b0;
		end
		if (wr_do) begin
			s_next.aw_hold = 1'b0;
			s_next.w_hold  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = (wr_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
			for (int b = 0; b < 2; b++) begin
				if (s_reg.wstrb[b] && wr_slot < SLOT_CTRL) begin
					s_next.areg[wr_slot[2:0]][b*8 +: 8] = s_reg.wdata[b*8 +: 8];
				end
				if (s_reg.wstrb[b] && wr_slot == SLOT_CTRL) begin
					s_next.ctrl[b*8 +: 8] = s_reg.wdata[b*8 +: 8];
				end
			end
		end
		// Read channel answers one cycle after the address is taken.
		if (s_reg.rvalid && s_axi_rready_i) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = (rslot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (rslot < SLOT_CTRL) begin
				s_next.rdata = s_reg.areg[rslot[2:0]];
			end else if (rslot == SLOT_CTRL) begin
				s_next.rdata = s_reg.ctrl;
			end else if (rslot == SLOT_STATUS) begin
				s_next.rdata = '0;
				s_next.rdata[STAT_BUSY_BIT] = (s_reg.st != ST_IDLE);
				s_next.rdata[STAT_IDX_LSB +: 6] = s_reg.idx;
			end else begin
				s_next.rdata = '0;
			end
		end
		// Step engine; its field write lands after any software write.
		case (s_reg.st)
			ST_IDLE: begin
				if (launch) begin
					s_next.idx = s_reg.wdata[5:0];
					s_next.st  = ST_FETCH;
				end
			end
			ST_FETCH: begin
				s_next.st = ST_APPLY;
			end
			ST_APPLY: begin
				rslot = reg_slot(step.addr);
				if (rslot < SLOT_CTRL) begin
					s_next.areg[rslot[2:0]] = (s_next.areg[rslot[2:0]] & ~mask)
						| (({8'h00, step.data} << step.start) & mask);
				end
				s_next.cnt = dly_cycles(step.dly) - 32'd1;
				s_next.end_of_sequence_flag = step.end_of_sequence_flag;
				s_next.st  = ST_WAIT;
			end
			default: begin
				if (s_reg.cnt != 32'd0) begin
					s_next.cnt = s_reg.cnt - 32'd1;
				end else if (s_reg.end_of_sequence_flag) begin
					s_next.st = ST_IDLE;
				end else begin
					s_next.idx = s_reg.idx + 6'd1;
					s_next.st  = ST_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_reg      <= '0;
			s_reg.st   <= ST_IDLE;
			s_reg.ctrl <= CTRL_RST;
			s_reg.areg <= {ANTIPOP_RST, ANTIPOP_RST, EAR_MUTE_RST, LINE_MUTE_RST,
				PWR_THREE_RST, PWR_ONE_RST};
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready_o = !s_reg.aw_hold && !s_reg.bvalid;
	assign s_axi_wready_o  = !s_reg.w_hold && !s_reg.bvalid;
	assign s_axi_bvalid_o  = s_reg.bvalid;
	assign s_axi_bresp_o   = s_reg.bresp;
	assign s_axi_arready_o = !s_reg.rvalid;
	assign s_axi_rvalid_o  = s_reg.rvalid;
	assign s_axi_rresp_o   = s_reg.rresp;
	assign s_axi_rdata_o   = {16'h0000, s_reg.rdata};
	assign pwr_one_o       = s_reg.areg[SLOT_PWR_ONE[2:0]];
	assign pwr_three_o     = s_reg.areg[SLOT_PWR_THREE[2:0]];
	assign line_mute_o     = s_reg.areg[SLOT_LINE_MUTE[2:0]];
	assign ear_mute_o      = s_reg.areg[SLOT_EAR_MUTE[2:0]];
	assign antipop_a_o     = s_reg.areg[SLOT_ANTIPOP_A[2:0]];
	assign antipop_b_o     = s_reg.areg[SLOT_ANTIPOP_B[2:0]];
	assign busy_o          = (s_reg.st != ST_IDLE);
	assign step_index_o    = s_reg.idx;

	logic go_apply;
	assign go_apply = ce_i && s_reg.st == ST_APPLY;

	a_start_spk: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && launch && s_reg.wdata == CTRL_SPEAKER |=> busy_o && step_index_o == 6'd16)
		else $error("speaker launch did not start at step 16");
	a_start_ear: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && launch && s_reg.wdata == CTRL_EARPIECE |=> busy_o && step_index_o == 6'd19)
		else $error("earpiece launch did not start at step 19");
	a_start_line: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && launch && s_reg.wdata == CTRL_LINEOUT |=> busy_o && step_index_o == 6'd25)
		else $error("line launch did not start at step 25");
	a_spk_enable: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd18 |=> pwr_one_o[13:12] == 2'b11)
		else $error("speaker enables not set by final step");
	a_ear_input: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd20 |=> antipop_a_o[6])
		else $error("earpiece input enable not set");
	a_ear_unmute: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd24 |=> !ear_mute_o[5] && s_reg.end_of_sequence_flag)
		else $error("earpiece not unmuted as end step");
	a_line_enable: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd28 |=> pwr_three_o[13:10] == 4'hf)
		else $error("line enables not set");
	a_line_unmute: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd33 |=> line_mute_o[2:1] == 2'b00 && line_mute_o[6:5] == 2'b00)
		else $error("line outputs not unmuted");
	a_field_keep: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd17 && !wr_do |=> pwr_one_o[15:3] == $past(pwr_one_o[15:3]))
		else $error("step write touched bits outside its field");
	a_end_stop: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && s_reg.st == ST_WAIT && s_reg.cnt == 32'd0 && s_reg.end_of_sequence_flag |=> !busy_o)
		else $error("sequencer did not stop after end step");
	a_delay_load: assert property (@(posedge clk_i) disable iff (srst_i)
		go_apply && step.dly == DLY_CODE_9 |=> s_reg.cnt == DLY_9_CYCLES - 1)
		else $error("delay code 9h loaded wrong count");

	c_spk_run: cover property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd18);
	c_ear_run: cover property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd24);
	c_line_run: cover property (@(posedge clk_i) disable iff (srst_i)
		go_apply && s_reg.idx == 6'd33);

endmodule
`default_nettype wire

// file: bench/ows_sequencer_tb_top.sv
// Self-checking testbench for the output start-up write sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ows_sequencer_tb_top
	import ows_pkg::*;
();
	// Short delays keep the run brief; every expected time is derived from them.
	localparam int unsigned D0 = 3;
	localparam int unsigned D9 = 5;
	localparam int unsigned DC = 7;
	localparam int unsigned DD = 9;
	localparam logic [15:0] LAUNCH [3] = '{16'h0110, 16'h0113, 16'h0119};
	localparam logic [5:0]  FIRST  [3] = '{6'd16, 6'd19, 6'd25};
	localparam logic [5:0]  LAST   [3] = '{6'd18, 6'd24, 6'd33};
	localparam int          CYC    [3] = '{3 * 2 + 2 * D0 + D9, 6 * 2 + 5 * D0 + DC,
		9 * 2 + 8 * D0 + DD};
	localparam logic [15:0] PWR1   [3] = '{16'h3003, 16'h0803, 16'h0003};
	localparam logic [15:0] PWR3   [3] = '{16'h0000, 16'h0000, 16'h3c00};
	localparam logic [15:0] LMUTE  [3] = '{16'h0066, 16'h0066, 16'h0000};
	localparam logic [15:0] EMUTE  [3] = '{16'h0020, 16'h0000, 16'h0020};
	localparam logic [15:0] APA    [3] = '{16'h0000, 16'h0040, 16'h0080};
	localparam logic [15:0] APB    [3] = '{16'hffef, 16'h004c, 16'h004c};
	localparam logic [15:0] PRE_B  [3] = '{16'hffff, 16'h0000, 16'h0000};
	localparam logic [15:0] SN_PWR [3] = '{16'h0003, 16'h0803, 16'h0003};
	localparam logic [15:0] SN_LN  [3] = '{16'h0066, 16'h0066, 16'h0006};

	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic [11:0] awaddr = '0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [11:0] araddr = '0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, busy_o;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] pwr_one_o, pwr_three_o, line_mute_o, ear_mute_o, antipop_a_o, antipop_b_o;
	logic [5:0]  step_index_o;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          busy_cnt = 0;

	always #2 clk_i = ~clk_i;
	always @(negedge clk_i) begin
		if (busy_o === 1'b1) begin
			busy_cnt++;
		end
	end

	ows_sequencer #(.DLY_0_CYCLES(D0), .DLY_9_CYCLES(D9), .DLY_C_CYCLES(DC),
		.DLY_D_CYCLES(DD)) u_dut (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.pwr_one_o(pwr_one_o), .pwr_three_o(pwr_three_o), .line_mute_o(line_mute_o),
		.ear_mute_o(ear_mute_o), .antipop_a_o(antipop_a_o), .antipop_b_o(antipop_b_o),
		.busy_o(busy_o), .step_index_o(step_index_o)
	);

	function automatic logic [11:0] addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	// Address and data are offered together and each is dropped once taken.
	task automatic axi_write(input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		@(posedge clk_i);
		awaddr <= addr(idx);
		wdata <= {16'h0000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] idx, output logic [31:0] d,
		output logic [1:0] resp);
		@(posedge clk_i);
		araddr <= addr(idx);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic do_reset;
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
	endtask

	// Launch one sequence, watch its last step land last, then check every register.
	task automatic run_case(input int k);
		logic [31:0] rd;
		logic [1:0]  rs;
		bit          snapped;
		int          n;
		do_reset();
		axi_write(ANTIPOP_B_IDX, PRE_B[k], 4'h3, rs);
		busy_cnt = 0;
		axi_write(SEQ_CTRL_IDX, LAUNCH[k], 4'h3, rs);
		#1;
		`CHK(busy_o, 1'b1)
		`CHK(step_index_o, FIRST[k])
		`CHK(rs, RESP_OKAY)
		axi_read(SEQ_STATUS_IDX, rd, rs);
		`CHK(rd[STAT_BUSY_BIT], 1'b1)
		`CHK(rd[STAT_IDX_LSB +: 6], FIRST[k])
		n = 0;
		snapped = 0;
		while (busy_o === 1'b1 && n < 400) begin
			@(posedge clk_i);
			#1;
			n++;
			if (!snapped && step_index_o === LAST[k]) begin
				snapped = 1;
				`CHK(pwr_one_o, SN_PWR[k])
				`CHK(line_mute_o, SN_LN[k])
				`CHK(ear_mute_o, 16'h0020)
			end
		end
		`CHK(snapped, 1'b1)
		`CHK(busy_cnt, CYC[k])
		`CHK(pwr_one_o, PWR1[k])
		`CHK(pwr_three_o, PWR3[k])
		`CHK(line_mute_o, LMUTE[k])
		`CHK(ear_mute_o, EMUTE[k])
		`CHK(antipop_a_o, APA[k])
		`CHK(antipop_b_o, APB[k])
		axi_read(ANTIPOP_B_IDX, rd, rs);
		`CHK(rd, {16'h0000, APB[k]})
		axi_read(SEQ_CTRL_IDX, rd, rs);
		`CHK(rd, {16'h0000, LAUNCH[k]})
	endtask

	// Near-miss launch values and a narrow strobe must not start anything; an unmapped index must read as zero with SLVERR.
	task automatic refusals;
		logic [31:0] rd;
		logic [1:0]  rs;
		do_reset();
		axi_write(SEQ_CTRL_IDX, 16'h0111, 4'h3, rs);
		#1;
		`CHK(busy_o, 1'b0)
		axi_write(SEQ_CTRL_IDX, 16'h0110, 4'h1, rs);
		#1;
		`CHK(busy_o, 1'b0)
		axi_write(SEQ_CTRL_IDX, 16'h0150, 4'h3, rs);
		#1;
		`CHK(busy_o, 1'b0)
		axi_read(8'hff, rd, rs);
		`CHK(rs, RESP_SLVERR)
		`CHK(rd, 32'h0000_0000)
		`CHK(pwr_one_o, 16'h0000)
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		`CHK(line_mute_o, 16'h0066)
		`CHK(ear_mute_o, 16'h0020)
		refusals();
		for (int k = 0; k < 3; k++) begin
			run_case(k);
		end
		print_verdict();
	end

	// The whole run needs well under a thousand cycles; this bounds any hang.
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
